/* hdl/rlc_regs.sv */
// Lane 6/7 control, link control, reinit gating and per-lane ILAS config capture behind Wishbone.
// Function
// - Lane power-down bit 1 drives power-off vector entry 6 or 7.
// - Exported power-off: 1 means lane powered down, 0 normal operation.
// - Polarity bit 0 set inverts that lane's receive data; resets to 0.
// - Lane spare bit 2 is read-write resetting to 1; bits 31:3 read zero.
// - Link spare bits 11 and 13-16 read-write, reset 0; bits 31:17 zero.
// - Reinit disable bit 12 set suppresses reinit except on code group error.
// - Global reinit disable overrides the per-error reinit enable register at 0x78.
// - Config octets from second ILAS multiframe latched per lane; selector bits 10:7.
// - Selector codes 0-7 route lane copy to 0xa0-0xac; other codes read zero.
//
// Implementation choice: the Wishbone interface to the registers.
module rlc_regs #(
   parameter int LANES = 8,
   parameter int DATA_W = 32,
   parameter int ERR_W = 8
) (
   input wire logic CLOCK, // 40 MHz clock
   input wire logic RST, // synchronous reset, active high
   input wire logic WB_CYC_I, // bus cycle
   input wire logic WB_STB_I, // strobe
   input wire logic WB_WE_I, // write enable
   input wire logic [7:0] WB_ADR_I, // byte address
   input wire logic [3:0] WB_SEL_I, // byte lane selects
   input wire logic [31:0] WB_DAT_I, // write data
   output logic [31:0] WB_DAT_O, // read data
   output logic WB_ACK_O, // acknowledge
   output logic [LANES-1:0] LANE_POWER_OFF, // per-lane power-down, 1 = down
   input wire logic [DATA_W-1:0] LANE_SIX_RX_DATA, // lane 6 incoming data
   input wire logic [DATA_W-1:0] LANE_SEVEN_RX_DATA, // lane 7 incoming data
   output logic [DATA_W-1:0] LANE_SIX_RX_OUT, // lane 6 data after polarity
   output logic [DATA_W-1:0] LANE_SEVEN_RX_OUT, // lane 7 data after polarity
   input wire logic [LANES-1:0] ILAS_CFG_VALID, // per-lane config capture pulse
   input wire logic [LANES*32*4-1:0] ILAS_CFG_DATA, // per-lane 4 config words
   input wire logic [ERR_W-1:0] LINK_ERR, // error pulses, bit 0 code group
   output logic REINIT_REQ // link reinitialization request pulse
);
   localparam int BYTE_W = rlc_pkg::BYTE_W;
   localparam int WORD_W = rlc_pkg::WORD_W;
   localparam int CFG_WORDS = rlc_pkg::CFG_WORDS;
   localparam int SEL_IDX_W = (LANES > 1) ? $clog2(LANES) : 1;
   localparam logic [31:0] ALL_BITS = '1;

   logic [31:0] lane_six_control_reg;
   logic [31:0] lane_six_control_next;
   logic [31:0] lane_seven_control_reg;
   logic [31:0] lane_seven_control_next;
   logic [31:0] link_layer_control_reg;
   logic [31:0] link_layer_control_next;
   logic [ERR_W-1:0] err_reinit_en_reg;
   logic [ERR_W-1:0] err_reinit_en_next;
   // Every lane keeps its own copy, so software can inspect any lane after alignment.
   logic [31:0] cfg_mem_reg [LANES][CFG_WORDS];
   logic [31:0] cfg_mem_next [LANES][CFG_WORDS];
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [DATA_W-1:0] six_out_reg;
   logic [DATA_W-1:0] six_out_next;
   logic [DATA_W-1:0] seven_out_reg;
   logic [DATA_W-1:0] seven_out_next;
   logic reinit_reg;
   logic reinit_next;
   logic bus_req;
   logic bus_take;
   logic wr_strobe;
   logic wr_six;
   logic wr_seven;
   logic wr_link;
   logic wr_err_en;
   logic [rlc_pkg::LINK_SEL_W-1:0] lane_sel;
   logic [SEL_IDX_W-1:0] cfg_idx;
   logic sel_valid;
   logic [31:0] err_mask_word;
   logic [ERR_W-1:0] reinit_cause;

   // Byte-lane merge; the mask keeps reserved positions at zero whatever is written.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < rlc_pkg::WORD_BYTES; b++) begin
         if (sel[b]) begin
            res[b*BYTE_W +: BYTE_W] = wd[b*BYTE_W +: BYTE_W];
         end
      end
      return res & mask;
   endfunction

   function automatic logic [DATA_W-1:0] apply_polarity(input logic [DATA_W-1:0] data,
                                                        input logic invert);
      logic [DATA_W-1:0] res;
      res = data;
      if (invert) begin
         res = ~data;
      end
      return res;
   endfunction

   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr == ofs;
   endfunction

   function automatic logic cfg_word_hit(input logic [7:0] adr, input int word);
      return reg_hit(adr, 8'(rlc_pkg::CFG_OCTET_BASE_OFS + rlc_pkg::WORD_BYTES * word));
   endfunction

   assign bus_req = WB_CYC_I && WB_STB_I;
   // A new access is taken only while ack is low, so a held strobe is not answered twice.
   assign bus_take = bus_req && !ack_reg;
   // Writes land at the edge where the master samples ack high; until then the master may
   // still be settling address and data, and nothing is lost by waiting one cycle.
   assign wr_strobe = bus_req && WB_WE_I && ack_reg;
   assign wr_six = wr_strobe && reg_hit(WB_ADR_I, rlc_pkg::LANE_SIX_CTRL_OFS);
   assign wr_seven = wr_strobe && reg_hit(WB_ADR_I, rlc_pkg::LANE_SEVEN_CTRL_OFS);
   assign wr_link = wr_strobe && reg_hit(WB_ADR_I, rlc_pkg::LINK_CTRL_OFS);
   assign wr_err_en = wr_strobe && reg_hit(WB_ADR_I, rlc_pkg::ERR_REINIT_EN_OFS);
   assign lane_sel = link_layer_control_reg[rlc_pkg::LINK_SEL_LSB +: rlc_pkg::LINK_SEL_W];
   assign cfg_idx = lane_sel[SEL_IDX_W-1:0];
   assign sel_valid = 32'(lane_sel) < LANES;
   assign err_mask_word = 32'(err_reinit_en_reg);

   always_comb begin
      ack_next = bus_take;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   always_comb begin
      lane_six_control_next = lane_six_control_reg;
      if (wr_six) begin
         lane_six_control_next = merge(lane_six_control_reg, WB_DAT_I, WB_SEL_I,
                                       rlc_pkg::LANE_CTRL_MASK);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         lane_six_control_reg <= rlc_pkg::LANE_CTRL_RESET;
      end else begin
         lane_six_control_reg <= lane_six_control_next;
      end
   end

   always_comb begin
      lane_seven_control_next = lane_seven_control_reg;
      if (wr_seven) begin
         lane_seven_control_next = merge(lane_seven_control_reg, WB_DAT_I, WB_SEL_I,
                                         rlc_pkg::LANE_CTRL_MASK);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         lane_seven_control_reg <= rlc_pkg::LANE_CTRL_RESET;
      end else begin
         lane_seven_control_reg <= lane_seven_control_next;
      end
   end

   always_comb begin
      link_layer_control_next = link_layer_control_reg;
      if (wr_link) begin
         link_layer_control_next = merge(link_layer_control_reg, WB_DAT_I, WB_SEL_I,
                                         rlc_pkg::LINK_CTRL_MASK);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         link_layer_control_reg <= rlc_pkg::LINK_CTRL_RESET;
      end else begin
         link_layer_control_reg <= link_layer_control_next;
      end
   end

   always_comb begin
      err_reinit_en_next = err_reinit_en_reg;
      if (wr_err_en) begin
         err_reinit_en_next = ERR_W'(merge(err_mask_word, WB_DAT_I, WB_SEL_I, ALL_BITS));
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         err_reinit_en_reg <= '1;
      end else begin
         err_reinit_en_reg <= err_reinit_en_next;
      end
   end

   always_comb begin
      cfg_mem_next = cfg_mem_reg;
      for (int l = 0; l < LANES; l++) begin
         if (ILAS_CFG_VALID[l]) begin
            for (int w = 0; w < CFG_WORDS; w++) begin
               cfg_mem_next[l][w] = ILAS_CFG_DATA[(l*CFG_WORDS + w)*WORD_W +: WORD_W];
            end
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int l = 0; l < LANES; l++) begin
            for (int w = 0; w < CFG_WORDS; w++) begin
               cfg_mem_reg[l][w] <= '0;
            end
         end
      end else begin
         cfg_mem_reg <= cfg_mem_next;
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (bus_take) begin
         case (WB_ADR_I)
            rlc_pkg::LANE_SIX_CTRL_OFS: rdata_next = lane_six_control_reg;
            rlc_pkg::LANE_SEVEN_CTRL_OFS: rdata_next = lane_seven_control_reg;
            rlc_pkg::LINK_CTRL_OFS: rdata_next = link_layer_control_reg;
            rlc_pkg::ERR_REINIT_EN_OFS: rdata_next = err_mask_word;
            default: rdata_next = '0;
         endcase
         for (int w = 0; w < CFG_WORDS; w++) begin
            if (cfg_word_hit(WB_ADR_I, w)) begin
               // An unpopulated selector code returns zero rather than a stale lane.
               rdata_next = sel_valid ? cfg_mem_reg[cfg_idx][w] : '0;
            end
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   always_comb begin
      six_out_next = apply_polarity(LANE_SIX_RX_DATA,
                                    lane_six_control_reg[rlc_pkg::LANE_INVERT_BIT]);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         six_out_reg <= '0;
      end else begin
         six_out_reg <= six_out_next;
      end
   end

   always_comb begin
      seven_out_next = apply_polarity(LANE_SEVEN_RX_DATA,
                                      lane_seven_control_reg[rlc_pkg::LANE_INVERT_BIT]);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         seven_out_reg <= '0;
      end else begin
         seven_out_reg <= seven_out_next;
      end
   end

   always_comb begin
      reinit_cause = LINK_ERR & err_reinit_en_reg;
      // The global disable wins over the per-error enables, but a code group error still passes.
      if (link_layer_control_reg[rlc_pkg::LINK_REINIT_DIS_BIT]) begin
         reinit_cause = reinit_cause & ERR_W'(1 << rlc_pkg::CODE_GROUP_ERR_BIT);
      end
      reinit_next = |reinit_cause;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         reinit_reg <= 1'b0;
      end else begin
         reinit_reg <= reinit_next;
      end
   end

   always_comb begin
      LANE_POWER_OFF = '0;
      LANE_POWER_OFF[rlc_pkg::LANE_SIX] = lane_six_control_reg[rlc_pkg::LANE_POWER_BIT];
      LANE_POWER_OFF[rlc_pkg::LANE_SEVEN] =
         lane_seven_control_reg[rlc_pkg::LANE_POWER_BIT];
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;
   assign LANE_SIX_RX_OUT = six_out_reg;
   assign LANE_SEVEN_RX_OUT = seven_out_reg;
   assign REINIT_REQ = reinit_reg;
endmodule

/* hdl/rlc_pkg.sv */
// Package with register map, field positions and reset values of the lane and link control bank.
package rlc_pkg;
   localparam logic [7:0] LANE_SIX_CTRL_OFS = 8'h1c;
   localparam logic [7:0] LANE_SEVEN_CTRL_OFS = 8'h20;
   localparam logic [7:0] LINK_CTRL_OFS = 8'h50;
   localparam logic [7:0] ERR_REINIT_EN_OFS = 8'h78;
   localparam logic [7:0] CFG_OCTET_BASE_OFS = 8'ha0;
   localparam int CFG_WORDS = 4;
   localparam int LANE_INVERT_BIT = 0;
   localparam int LANE_POWER_BIT = 1;
   localparam int LANE_SPARE_BIT = 2;
   localparam logic [31:0] LANE_CTRL_MASK = 32'h0000_0007;
   localparam logic [31:0] LANE_CTRL_RESET = 32'h0000_0004;
   localparam int LINK_SEL_LSB = 7;
   localparam int LINK_SEL_W = 4;
   localparam int LINK_REINIT_DIS_BIT = 12;
   localparam logic [31:0] LINK_CTRL_MASK = 32'h0001_ff80;
   localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0000;
   localparam int LANE_SIX = 6;
   localparam int LANE_SEVEN = 7;
   localparam int CODE_GROUP_ERR_BIT = 0;
   localparam int BYTE_W = 8;
   localparam int WORD_BYTES = 4;
   localparam int WORD_W = 32;
endpackage

/* tb/rlc_regs_props.sv */
// Checker for bus handshake, lane outputs and reinit gating of the control bank.
module rlc_props #(parameter int LANES = 8, parameter int DATA_W = 32, parameter int ERR_W = 8) (
   input wire logic CLOCK, // clock
   input wire logic RST, // reset
   input wire logic WB_CYC_I, // cycle
   input wire logic WB_STB_I, // strobe
   input wire logic WB_WE_I, // write
   input wire logic [7:0] WB_ADR_I, // address
   input wire logic [3:0] WB_SEL_I, // byte selects
   input wire logic [31:0] WB_DAT_I, // write data
   input wire logic [31:0] WB_DAT_O, // read data
   input wire logic WB_ACK_O, // ack
   input wire logic [LANES-1:0] LANE_POWER_OFF, // power-off
   input wire logic [DATA_W-1:0] LANE_SIX_RX_DATA, // lane 6 in
   input wire logic [DATA_W-1:0] LANE_SIX_RX_OUT, // lane 6 out
   input wire logic [ERR_W-1:0] LINK_ERR, // errors
   input wire logic REINIT_REQ // reinit
);
   logic inv6_reg;
   // Shadow of the lane 6 invert bit, taken at the edge where a write is acknowledged.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         inv6_reg <= 1'b0;
      end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h1c
                   && WB_SEL_I[0]) begin
         inv6_reg <= WB_DAT_I[0];
      end
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("request not answered");
   power_low_a: assert property (LANE_POWER_OFF[5:0] == 6'h00) else $error("low lanes set");
   power_six_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h1c
      && WB_SEL_I[0] |=> LANE_POWER_OFF[6] == $past(WB_DAT_I[1])) else $error("lane 6 power wrong");
   power_seven_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h20
      && WB_SEL_I[0] |=> LANE_POWER_OFF[7] == $past(WB_DAT_I[1])) else $error("lane 7 power wrong");
   invert_path_a: assert property (1 |=> LANE_SIX_RX_OUT == ($past(inv6_reg) ?
      ~$past(LANE_SIX_RX_DATA) : $past(LANE_SIX_RX_DATA))) else $error("lane 6 data wrong");
   link_reserved_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h50
      |-> WB_DAT_O[31:17] == 15'h0) else $error("link reserved bits set");
   code_group_a: assert property (LINK_ERR[0] |=> REINIT_REQ) else $error("no reinit");
   reserved_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I inside {8'h1c, 8'h20}
      |-> WB_DAT_O[31:3] == 29'h0) else $error("reserved bits set");
endmodule
bind rlc_regs rlc_props #(.LANES(LANES), .DATA_W(DATA_W), .ERR_W(ERR_W)) rlc_props_inst (.CLOCK,
   .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
   .LANE_POWER_OFF, .LANE_SIX_RX_DATA, .LANE_SIX_RX_OUT, .LINK_ERR, .REINIT_REQ);

/* tb/tb_top.sv */
// Self-checking bench for the lane and link control bank.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, WB_ACK_O, REINIT_REQ;
   logic [7:0] WB_ADR_I = 8'h00, LANE_POWER_OFF, ILAS_CFG_VALID = 8'h00, LINK_ERR = 8'h00;
   logic [3:0] WB_SEL_I = 4'hf;
   logic [31:0] WB_DAT_I = 32'h0, LANE_SIX_RX_DATA = 32'h0, LANE_SEVEN_RX_DATA = 32'h0;
   logic [31:0] WB_DAT_O, LANE_SIX_RX_OUT, LANE_SEVEN_RX_OUT, rd;
   logic [1023:0] ILAS_CFG_DATA = '0;
   int n_errors = 0, cmp_count = 0;
   rlc_regs rlc_regs_inst (.CLOCK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
      .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .LANE_POWER_OFF, .LANE_SIX_RX_DATA, .LANE_SEVEN_RX_DATA,
      .LANE_SIX_RX_OUT, .LANE_SEVEN_RX_OUT, .ILAS_CFG_VALID, .ILAS_CFG_DATA, .LINK_ERR, .REINIT_REQ);
   initial forever #12.5 CLOCK = ~CLOCK;
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // The master holds every request signal until it samples ack at a rising edge.
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_SEL_I <= s;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge CLOCK);
   endtask
   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   task err(input logic [7:0] e, input logic x);
      LINK_ERR <= e;
      @(posedge CLOCK);
      LINK_ERR <= 8'h00;
      @(negedge CLOCK);
      chk("reinit", REINIT_REQ, x);
      @(posedge CLOCK);
   endtask
   task t_reset;
      rdchk("six reset", 8'h1c, 32'h4);
      rdchk("seven reset", 8'h20, 32'h4);
      rdchk("link reset", 8'h50, 32'h0);
      rdchk("unmapped", 8'h00, 32'h0);
      $display("test reset done");
   endtask
   task t_lane;
      wb(1'b1, 8'h1c, 32'hffff_fffb);
      rdchk("six ctrl", 8'h1c, 32'h3);
      LANE_SIX_RX_DATA <= 32'h1234_5678;
      LANE_SEVEN_RX_DATA <= 32'h0f0f_0f0f;
      wb(1'b1, 8'h20, 32'h2);
      chk("power", LANE_POWER_OFF, 8'hc0);
      chk("reset mask", 8'(~LANE_POWER_OFF), 8'h3f);
      chk("six out", LANE_SIX_RX_OUT, 32'hedcb_a987);
      chk("seven out", LANE_SEVEN_RX_OUT, 32'h0f0f_0f0f);
      wb(1'b1, 8'h50, 32'hffff_ffff);
      rdchk("link ctrl", 8'h50, 32'h0001_ff80);
      $display("test lane done");
   endtask
   task t_reinit;
      err(8'h02, 1'b0);
      err(8'h01, 1'b1);
      wb(1'b1, 8'h50, 32'h0);
      err(8'h02, 1'b1);
      wb(1'b1, 8'h78, 32'hfd);
      err(8'h02, 1'b0);
      $display("test reinit done");
   endtask
   task t_ilas;
      for (int w = 0; w < 4; w++) ILAS_CFG_DATA[(24 + w) * 32 +: 32] <= 32'hc0de_0000 + w;
      ILAS_CFG_VALID <= 8'h40;
      @(posedge CLOCK);
      ILAS_CFG_VALID <= 8'h00;
      wb(1'b1, 8'h50, 32'h300);
      for (int w = 0; w < 4; w++) rdchk("octet", 8'ha0 + 8'(w * 4), 32'hc0de_0000 + w);
      wb(1'b1, 8'h50, 32'h400);
      rdchk("bad select", 8'ha0, 32'h0);
      wb(1'b1, 8'h50, 32'hffff_ffff, 4'h2);
      rdchk("link byte", 8'h50, 32'h0000_ff00);
      $display("test ilas done");
   endtask
   initial begin
      repeat (20) @(posedge CLOCK);
      RST <= 1'b0;
      @(posedge CLOCK);
      t_reset;
      t_lane;
      t_reinit;
      t_ilas;
      end_sim;
   end
   initial begin
      repeat (3000) @(posedge CLOCK);
      n_errors++;
      end_sim;
   end
endmodule
